// file: design/digital_io.sv
// Ninety-six line digital I/O: twelve byte ports, direction control,
// absolute and relative byte and bit access, interrupt source line.
// Assumes pins are synchronous to mclk and the external pull-ups hold
// undriven lines high.
`timescale 1ns/100ps
`default_nettype none

module digital_io #(
  parameter int NUM_PORTS = dio_pkg::NUM_PORTS,
  parameter int PORT_W    = dio_pkg::PORT_W
) (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic [NUM_PORTS-1:0]          cfg_default,
  input  wire logic                          cmd_valid,
  output var  logic                          cmd_ready,
  input  wire logic                          cmd_write,
  input  wire dio_pkg::access_mode_t         cmd_mode,
  input  wire logic [dio_pkg::ADDR_W-1:0]    cmd_addr,
  input  wire logic [PORT_W-1:0]             cmd_wdata,
  output var  logic                          rsp_valid,
  output var  logic [PORT_W-1:0]             rsp_data,
  output var  logic                          rsp_error,
  input  wire logic [NUM_PORTS*PORT_W-1:0]   pin_in,
  output var  logic [NUM_PORTS*PORT_W-1:0]   pin_out,
  output var  logic [NUM_PORTS*PORT_W-1:0]   pin_oe,
  output var  logic                          irq_src
);

  localparam int IDX_W = dio_pkg::IDX_W;

  typedef enum logic {
    ST_IDLE,
    ST_WAIT
  } state_t;

  // Absolute byte decode: maps a printed offset to a port slot.
  function automatic logic [IDX_W:0] abs_decode(input logic [IDX_W-1:0] off);
    logic [IDX_W:0] r;
    r = '0;
    unique case (off)
      dio_pkg::BANK_ONE_FIRST_PORT_DATA:    r = {1'b1, off};
      dio_pkg::BANK_ONE_SECOND_PORT_DATA:   r = {1'b1, off};
      dio_pkg::BANK_ONE_THIRD_PORT_DATA:    r = {1'b1, off};
      dio_pkg::BANK_TWO_FIRST_PORT_DATA:    r = {1'b1, off};
      dio_pkg::BANK_TWO_SECOND_PORT_DATA:   r = {1'b1, off};
      dio_pkg::BANK_TWO_THIRD_PORT_DATA:    r = {1'b1, off};
      dio_pkg::BANK_THREE_FIRST_PORT_DATA:  r = {1'b1, off};
      dio_pkg::BANK_THREE_SECOND_PORT_DATA: r = {1'b1, off};
      dio_pkg::BANK_THREE_THIRD_PORT_DATA:  r = {1'b1, off};
      dio_pkg::BANK_FOUR_FIRST_PORT_DATA:   r = {1'b1, off};
      dio_pkg::BANK_FOUR_SECOND_PORT_DATA:  r = {1'b1, off};
      dio_pkg::BANK_FOUR_THIRD_PORT_DATA:   r = {1'b1, off};
      // Offsets 12 to 15 fall to the default and come back as a miss.
      default:                              r = '0;
    endcase
    return r;
  endfunction : abs_decode

  // Relative decode: finds the n-th port of the wanted direction,
  // counting in offset order, which is bank order then first to third.
  function automatic logic [IDX_W:0] rel_decode(
    input logic [NUM_PORTS-1:0] dir,
    input logic                 want_out,
    input logic [IDX_W-1:0]     n
  );
    logic [IDX_W:0]   r;
    logic [IDX_W-1:0] cnt;
    r   = '0;
    cnt = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (dir[i] == want_out) begin
        // Only the first match is kept; later ports of the same direction
        // still advance the count but cannot overwrite it.
        if ((cnt == n) && !r[IDX_W]) begin
          r = {1'b1, IDX_W'(i)};
        end
        cnt = cnt + 1'b1;
      end
    end
    return r;
  endfunction : rel_decode

  // Command and state registers.
  state_t                state_q;
  logic                  ready_q;
  logic                  loaded_q;
  logic [NUM_PORTS-1:0]  dir_q;
  logic                  rsp_valid_q;
  logic [PORT_W-1:0]     rsp_data_q;
  logic                  rsp_error_q;
  logic [NUM_PORTS*PORT_W-1:0] oe_q;
  logic                  irq_q;

  // Request held across the memory read.
  dio_pkg::access_mode_t mode_q;
  logic                  write_q;
  logic                  err_q;
  logic [IDX_W-1:0]      idx_q;
  logic [2:0]            bit_q;
  logic                  dir_hi_q;

  // Decoded current request.
  logic                  take;
  logic                  hit_d;
  logic [IDX_W-1:0]      idx_d;
  logic [2:0]            bit_d;
  logic                  mem_we;
  logic [PORT_W-1:0]     mem_wdata;
  logic [PORT_W-1:0]     mem_mask;
  logic [PORT_W-1:0]     mem_rdata;
  logic [NUM_PORTS*PORT_W-1:0] out_bytes;
  logic [PORT_W-1:0]     port_val;

  // A request is taken on the edge that sees valid with ready; ready is a
  // register, so a taken request never races the state update.
  assign take = cmd_valid && ready_q;

  // Address decode for every access kind.
  always_comb begin
    logic [IDX_W:0] dec;
    dec   = '0;
    bit_d = cmd_addr[2:0];
    unique case (cmd_mode)
      dio_pkg::MODE_ABS_BYTE: begin
        dec   = abs_decode(cmd_addr[IDX_W-1:0]);
        // Offsets above the low nibble would otherwise alias onto ports.
        if (cmd_addr[dio_pkg::ADDR_W-1:IDX_W] != '0) begin
          dec = '0;
        end
      end
      dio_pkg::MODE_REL_BYTE: begin
        dec   = rel_decode(dir_q, cmd_write, cmd_addr[IDX_W-1:0]);
        // Indices above the low nibble can never name a port.
        if (cmd_addr[dio_pkg::ADDR_W-1:IDX_W] != '0) begin
          dec = '0;
        end
      end
      dio_pkg::MODE_ABS_BIT: begin
        // The top four address bits name the port, the low three the bit.
        dec   = abs_decode(cmd_addr[dio_pkg::ADDR_W-1:3]);
      end
      dio_pkg::MODE_REL_BIT: begin
        dec   = rel_decode(dir_q, cmd_write, cmd_addr[dio_pkg::ADDR_W-1:3]);
      end
      dio_pkg::MODE_DIR: begin
        dec   = {(cmd_addr == dio_pkg::DIR_WORD_LOW) ||
                 (cmd_addr == dio_pkg::DIR_WORD_HIGH), {IDX_W{1'b0}}};
      end
      default: begin
        dec   = '0;
      end
    endcase
    hit_d = dec[IDX_W];
    idx_d = dec[IDX_W-1:0];
  end

  // Write path into the output registers; relative writes only reach
  // output ports, absolute writes reach any port.
  always_comb begin
    mem_we    = 1'b0;
    mem_wdata = cmd_wdata;
    mem_mask  = '1;
    if (take && cmd_write && hit_d && (cmd_mode != dio_pkg::MODE_DIR)) begin
      mem_we = 1'b1;
      if ((cmd_mode == dio_pkg::MODE_ABS_BIT) ||
          (cmd_mode == dio_pkg::MODE_REL_BIT)) begin
        // Bit writes copy data bit 0 everywhere and let the mask pick one.
        mem_wdata = {PORT_W{cmd_wdata[0]}};
        mem_mask  = PORT_W'(1) << bit_d;
      end
    end
  end

  // Read and write share the decoded index; they never collide because
  // only one request is in flight at a time.
  port_store #(
    .N     (NUM_PORTS),
    .W     (PORT_W),
    .IDX_W (IDX_W)
  ) u_store (
    .mclk     (mclk),
    .srst     (srst),
    .we       (mem_we),
    .wr_idx   (idx_d),
    .wr_data  (mem_wdata),
    .wr_mask  (mem_mask),
    .rd_idx   (idx_d),
    .rd_data  (mem_rdata),
    .contents (out_bytes)
  );

  // Pins take the stored bytes as written, with no inversion.
  assign pin_out = out_bytes;

  // Command sequencing: one request in flight, answered two edges later.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_WAIT;
            ready_q <= 1'b0;
          end else begin
            ready_q <= 1'b1;
          end
        end
        // Ready returns one edge after a take, so takes stand two edges apart.
        ST_WAIT: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // Request fields held for the answer cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q   <= dio_pkg::MODE_ABS_BYTE;
      write_q  <= 1'b0;
      err_q    <= 1'b0;
      idx_q    <= '0;
      bit_q    <= '0;
      dir_hi_q <= 1'b0;
    end else if (take) begin
      mode_q   <= cmd_mode;
      write_q  <= cmd_write;
      err_q    <= !hit_d;
      idx_q    <= idx_d;
      bit_q    <= bit_d;
      dir_hi_q <= (cmd_addr == dio_pkg::DIR_WORD_HIGH);
    end
  end

  // Direction control: inputs at reset, then the saved set, then
  // whatever software writes through the control words.
  // The saved set is taken once, on the first edge out of reset, so a
  // later change of cfg_default has no effect until the next reset.
  always_ff @(posedge mclk) begin
    if (srst) begin
      dir_q    <= dio_pkg::DIR_RESET;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      dir_q    <= cfg_default;
      loaded_q <= 1'b1;
    end else if (take && cmd_write && hit_d &&
                 (cmd_mode == dio_pkg::MODE_DIR)) begin
      if (cmd_addr == dio_pkg::DIR_WORD_HIGH) begin
        dir_q[NUM_PORTS-1:dio_pkg::DIR_LOW_W] <=
          cmd_wdata[dio_pkg::DIR_HIGH_W-1:0];
      end else begin
        dir_q[dio_pkg::DIR_LOW_W-1:0] <= cmd_wdata;
      end
    end
  end

  // Each port's eight enables follow its direction bit as a group.
  always_ff @(posedge mclk) begin
    if (srst) begin
      oe_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        oe_q[i*PORT_W +: PORT_W] <= {PORT_W{dir_q[i]}};
      end
    end
  end

  assign pin_oe = oe_q;

  // Value seen by a read: pins inverted for inputs, complement of the
  // output register for outputs.
  // An output read never looks at the pins, so contention on the field
  // side cannot change what software sees.
  always_comb begin
    if (dir_q[idx_q]) begin
      port_val = ~mem_rdata;
    end else begin
      port_val = ~pin_in[idx_q*PORT_W +: PORT_W];
    end
  end

  // Answer: one-cycle valid with data or an error flag.
  // Writes and refused requests answer with zero data.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
      rsp_error_q <= 1'b0;
    end else if (state_q == ST_WAIT) begin
      rsp_valid_q <= 1'b1;
      rsp_error_q <= err_q;
      rsp_data_q  <= '0;
      if (!err_q && !write_q) begin
        unique case (mode_q)
          dio_pkg::MODE_ABS_BYTE,
          dio_pkg::MODE_REL_BYTE: begin
            rsp_data_q <= port_val;
          end
          dio_pkg::MODE_ABS_BIT,
          dio_pkg::MODE_REL_BIT: begin
            rsp_data_q <= {{(PORT_W-1){1'b0}}, port_val[bit_q]};
          end
          dio_pkg::MODE_DIR: begin
            if (dir_hi_q) begin
              rsp_data_q <= PORT_W'(dir_q[NUM_PORTS-1:dio_pkg::DIR_LOW_W]);
            end else begin
              rsp_data_q <= dir_q[dio_pkg::DIR_LOW_W-1:0];
            end
          end
          default: begin
            rsp_data_q <= '0;
          end
        endcase
      end
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      rsp_data_q  <= '0;
    end
  end

  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;
  assign rsp_error = rsp_error_q;

  // Interrupt source: the read sense of the first line of the first port.
  // The register keeps the sampler off the raw pin path, at the cost of
  // one cycle of latency.
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ~pin_in[dio_pkg::IRQ_LINE];
    end
  end

  assign irq_src = irq_q;

endmodule : digital_io

`default_nettype wire

// file: design/dio_pkg.sv
// Constants and types shared by the ninety-six line digital I/O block.
// Assumes a single 200 MHz clock domain and a synchronous active-high reset.
//
// Functional notes
// - A line held high reads back as 0 and a line held low reads back as 1.
// - An undriven line is pulled high outside, so it reads back as 0.
// - Reading an output port returns the complement of its output register.
// - Each port owns an output register kept in either direction.
// - Output data is not inverted: a written 1 drives the line high.
// - Bit 0 of the first port of the first bank is the only interrupt source.
// - Each port is turned to input or output as a whole by control words.
// - After reset the saved direction set applies until software overrides.
// - Absolute byte offsets 0 to 11 run bank by bank, first to third port.
// - The absolute bit address is eight times the port offset plus the bit.
// - Absolute maps never change while relative maps follow the directions.
// - Relative numbering counts inputs and outputs apart, each from 0 upward.
// - There are twelve eight-bit ports in four banks of three ports each.

package dio_pkg;

  // Geometry of the port array.
  localparam int NUM_BANKS      = 4;
  localparam int PORTS_PER_BANK = 3;
  localparam int NUM_PORTS      = NUM_BANKS * PORTS_PER_BANK;
  localparam int PORT_W         = 8;
  localparam int NUM_LINES      = NUM_PORTS * PORT_W;
  localparam int IDX_W          = 4;
  localparam int ADDR_W         = 7;

  // Absolute byte offsets of the port data registers.
  localparam logic [IDX_W-1:0] BANK_ONE_FIRST_PORT_DATA    = 4'h0;
  localparam logic [IDX_W-1:0] BANK_ONE_SECOND_PORT_DATA   = 4'h1;
  localparam logic [IDX_W-1:0] BANK_ONE_THIRD_PORT_DATA    = 4'h2;
  localparam logic [IDX_W-1:0] BANK_TWO_FIRST_PORT_DATA    = 4'h3;
  localparam logic [IDX_W-1:0] BANK_TWO_SECOND_PORT_DATA   = 4'h4;
  localparam logic [IDX_W-1:0] BANK_TWO_THIRD_PORT_DATA    = 4'h5;
  localparam logic [IDX_W-1:0] BANK_THREE_FIRST_PORT_DATA  = 4'h6;
  localparam logic [IDX_W-1:0] BANK_THREE_SECOND_PORT_DATA = 4'h7;
  localparam logic [IDX_W-1:0] BANK_THREE_THIRD_PORT_DATA  = 4'h8;
  localparam logic [IDX_W-1:0] BANK_FOUR_FIRST_PORT_DATA   = 4'h9;
  localparam logic [IDX_W-1:0] BANK_FOUR_SECOND_PORT_DATA  = 4'ha;
  localparam logic [IDX_W-1:0] BANK_FOUR_THIRD_PORT_DATA   = 4'hb;

  // Control word offsets: low word holds ports 0-7, high word ports 8-11.
  localparam logic [ADDR_W-1:0] DIR_WORD_LOW  = 7'h00;
  localparam logic [ADDR_W-1:0] DIR_WORD_HIGH = 7'h01;
  localparam int                DIR_LOW_W     = 8;
  localparam int                DIR_HIGH_W    = NUM_PORTS - DIR_LOW_W;

  // Values after reset.
  localparam logic [NUM_PORTS-1:0] DIR_RESET = 12'h000;
  localparam logic [PORT_W-1:0]    OUT_RESET = 8'h00;

  // Line that feeds the interrupt sampler.
  localparam int IRQ_LINE = 0;

  // Kind of access carried by one command.
  typedef enum logic [2:0] {
    MODE_ABS_BYTE,
    MODE_REL_BYTE,
    MODE_ABS_BIT,
    MODE_REL_BIT,
    MODE_DIR
  } access_mode_t;

endpackage : dio_pkg

// file: design/port_store.sv
// Output register file: one byte per port with masked writes.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/100ps
`default_nettype none

module port_store #(
  parameter int N     = 12,
  parameter int W     = 8,
  parameter int IDX_W = 4
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             we,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [W-1:0]     wr_data,
  input  wire logic [W-1:0]     wr_mask,
  input  wire logic [IDX_W-1:0] rd_idx,
  output var  logic [W-1:0]     rd_data,
  output var  logic [N*W-1:0]   contents
);

  logic [W-1:0] mem_q [N];
  logic [W-1:0] rd_q;

  // Masked byte write; the stored value never depends on the direction.
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= dio_pkg::OUT_RESET;
      end
    end else if (we && (int'(wr_idx) < N)) begin
      mem_q[wr_idx] <= (mem_q[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Registered read; an index past the end reads as zero.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_q <= dio_pkg::OUT_RESET;
    end else if (int'(rd_idx) < N) begin
      rd_q <= mem_q[rd_idx];
    end else begin
      rd_q <= '0;
    end
  end

  assign rd_data = rd_q;

  // All stored bytes flattened for the pin drivers.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      contents[i*W +: W] = mem_q[i];
    end
  end

endmodule : port_store

`default_nettype wire

// file: sim/digital_io_props.sv
// Port checker for the digital I/O block.
// Assumes it is bound to digital_io and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none

module digital_io_props #(
  parameter int NUM_PORTS = 12,
  parameter int PORT_W    = 8
) (
  input wire logic                        mclk,
  input wire logic                        srst,
  input wire logic [NUM_PORTS-1:0]        cfg_default,
  input wire logic                        cmd_valid,
  input wire logic                        cmd_ready,
  input wire logic                        cmd_write,
  input wire dio_pkg::access_mode_t       cmd_mode,
  input wire logic [dio_pkg::ADDR_W-1:0]  cmd_addr,
  input wire logic [PORT_W-1:0]           cmd_wdata,
  input wire logic                        rsp_valid,
  input wire logic [PORT_W-1:0]           rsp_data,
  input wire logic                        rsp_error,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_out,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_oe,
  input wire logic                        irq_src
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // Taken requests, plain and direction writes.
  logic tk;
  logic dir_tk;
  assign tk     = cmd_valid && cmd_ready;
  assign dir_tk = tk && cmd_write && cmd_mode == dio_pkg::MODE_DIR;

  answer_time_a: assert property (tk |=> !rsp_valid ##1 rsp_valid)
    else $error("answer not two edges after take");
  ready_gap_a: assert property (tk |=> !cmd_ready ##1 cmd_ready)
    else $error("ready gap after take wrong");
  write_zero_a: assert property (tk && cmd_write
    |-> ##2 rsp_data == '0)
    else $error("write answer carries data");
  abs_range_a: assert property (tk
    && cmd_mode == dio_pkg::MODE_ABS_BYTE
    |-> ##2 rsp_error == ($past(cmd_addr, 2) > 7'h0b))
    else $error("absolute range error flag wrong");
  out_write_a: assert property (tk && cmd_write && cmd_addr < 7'h0c
    && cmd_mode == dio_pkg::MODE_ABS_BYTE
    |=> pin_out[int'($past(cmd_addr))*PORT_W +: PORT_W] == $past(cmd_wdata))
    else $error("output byte not the written value");
  out_hold_a: assert property (!(tk && cmd_write)
    |=> $stable(pin_out))
    else $error("output register moved without a write");
  dir_only_a: assert property ($changed(pin_oe)
    |-> $past(dir_tk, 2) || $past(srst, 2) || $past(srst, 3))
    else $error("drive enable moved without a direction write");
  irq_track_a: assert property (!$past(srst) && !$past(srst, 2)
    |-> irq_src == !$past(pin_in[dio_pkg::IRQ_LINE]))
    else $error("interrupt source not inverted line zero");
  // Each port turns around as a whole group.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    oe_group_a: assert property (pin_oe[p*PORT_W +: PORT_W] == '0
      || pin_oe[p*PORT_W +: PORT_W] == '1)
      else $error("drive enable split inside a port");
  end
endmodule : digital_io_props

bind digital_io digital_io_props #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W))
  props_i (.mclk, .srst, .cfg_default, .cmd_valid, .cmd_ready, .cmd_write,
  .cmd_mode, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_error,
  .pin_in, .pin_out, .pin_oe, .irq_src);

`default_nettype wire

// file: sim/field_wiring.sv
// Field side of the ninety-six lines: external drivers and the pull-ups.
// Assumes the bench sets per-line enables and values for the field.
`timescale 1ns/100ps
`default_nettype none

module field_wiring (
  input  wire logic [95:0] pin_out,
  input  wire logic [95:0] pin_oe,
  input  wire logic [95:0] ext_val,
  input  wire logic [95:0] ext_en,
  output var  logic [95:0] pin_in
);
  // The board wins where it drives, then the field, else the pull-up.
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en);
  end
endmodule : field_wiring

`default_nettype wire

// file: sim/ninety_six_line_digital_io_tb_top.sv
// Self-checking bench for the digital I/O block with field wiring.
// Assumes the checker is bound in and the field model sits on the pins.
`timescale 1ns/100ps
`default_nettype none

module ninety_six_line_digital_io_tb_top;
  logic                  mclk        = 1'b0;
  logic                  srst        = 1'b1;
  logic [11:0]           cfg_default = 12'h002;
  logic                  cmd_valid   = 1'b0;
  logic                  cmd_write   = 1'b0;
  dio_pkg::access_mode_t cmd_mode    = dio_pkg::MODE_ABS_BYTE;
  logic [6:0]            cmd_addr    = 7'h00;
  logic [7:0]            cmd_wdata   = 8'h00;
  logic [95:0]           ext_val     = 96'h0;
  logic [95:0]           ext_en      = 96'h0;
  logic                  cmd_ready, rsp_valid, rsp_error, irq_src;
  logic [7:0]            rsp_data, rd;
  logic [95:0]           pin_in, pin_out, pin_oe;
  logic                  er;
  int                    n_fail      = 0;
  int                    tests_run   = 0;

  // Clock of 5 ns.
  always #2.5 mclk = ~mclk;

  digital_io DUT (.mclk, .srst, .cfg_default, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_mode, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_data,
    .rsp_error, .pin_in, .pin_out, .pin_oe, .irq_src);
  field_wiring wires (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

  // Compares one byte and counts it.
  task automatic chk(input string name, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // One request held until taken, then the answer is caught.
  task automatic xfer(input logic w, input dio_pkg::access_mode_t m,
                      input logic [6:0] a, input logic [7:0] d);
    int k;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_mode  = m;
    cmd_addr  = a;
    cmd_wdata = d;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 8) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 4) begin
      @(negedge mclk);
      k++;
    end
    chk("answer_wait", 8'h00, {7'h00, k == 4});
    rd = rsp_data;
    er = rsp_error;
  endtask : xfer

  // Saved directions come up and a floating line reads zero.
  task automatic t_start;
    chk("oe_port1", 8'hff, pin_oe[15:8]);
    chk("oe_port0", 8'h00, pin_oe[7:0]);
    xfer(1'b0, dio_pkg::MODE_ABS_BYTE, 7'h00, 8'h00);
    chk("float_read", 8'h00, rd);
  endtask : t_start

  // Driven inputs read inverted, bit zero feeds the interrupt source.
  task automatic t_inputs;
    ext_en[7:0]  = 8'hff;
    ext_val[7:0] = 8'h5a;
    xfer(1'b0, dio_pkg::MODE_ABS_BYTE, 7'h00, 8'h00);
    chk("in_byte", 8'ha5, rd);
    xfer(1'b0, dio_pkg::MODE_ABS_BIT, 7'h03, 8'h00);
    chk("in_bit3", 8'h00, rd);
    xfer(1'b0, dio_pkg::MODE_ABS_BIT, 7'h00, 8'h00);
    chk("in_bit0", 8'h01, rd);
    chk("irq_low_line", 8'h01, {7'h00, irq_src});
    ext_val[0] = 1'b1;
    repeat (2) @(negedge mclk);
    chk("irq_high_line", 8'h00, {7'h00, irq_src});
  endtask : t_inputs

  // Preset an input port, then turn it to output.
  task automatic t_preset;
    xfer(1'b1, dio_pkg::MODE_ABS_BYTE, 7'h04, 8'h3c);
    chk("preset_oe", 8'h00, pin_oe[39:32]);
    chk("preset_out", 8'h3c, pin_out[39:32]);
    xfer(1'b1, dio_pkg::MODE_DIR, 7'h00, 8'h12);
    chk("turn_oe", 8'hff, pin_oe[39:32]);
    chk("turn_line", 8'h3c, pin_in[39:32]);
    xfer(1'b0, dio_pkg::MODE_ABS_BYTE, 7'h04, 8'h00);
    chk("out_readback", 8'hc3, rd);
    xfer(1'b0, dio_pkg::MODE_DIR, 7'h00, 8'h00);
    chk("dir_low", 8'h12, rd);
    xfer(1'b0, dio_pkg::MODE_DIR, 7'h01, 8'h00);
    chk("dir_high", 8'h00, rd);
  endtask : t_preset

  // Absolute bit writes, edge addresses and refused places.
  task automatic t_bits;
    xfer(1'b1, dio_pkg::MODE_ABS_BIT, 7'h27, 8'h01);
    chk("bit39", 8'hbc, pin_out[39:32]);
    xfer(1'b1, dio_pkg::MODE_ABS_BIT, 7'h5f, 8'h01);
    chk("bit95", 8'h80, pin_out[95:88]);
    xfer(1'b0, dio_pkg::MODE_ABS_BYTE, 7'h0c, 8'h00);
    chk("abs_12", 8'h01, {7'h00, er});
    xfer(1'b1, dio_pkg::MODE_DIR, 7'h02, 8'hff);
    chk("dir_bad", 8'h01, {7'h00, er});
    chk("dir_kept", 8'h00, pin_oe[23:16]);
  endtask : t_bits

  // Relative numbering with ports 1 and 4 as outputs.
  task automatic t_relative;
    ext_en[23:16]  = 8'hff;
    ext_val[23:16] = 8'h0f;
    xfer(1'b0, dio_pkg::MODE_REL_BYTE, 7'h01, 8'h00);
    chk("rel_in1", 8'hf0, rd);
    xfer(1'b0, dio_pkg::MODE_ABS_BYTE, 7'h02, 8'h00);
    chk("abs_same", 8'hf0, rd);
    xfer(1'b1, dio_pkg::MODE_REL_BYTE, 7'h01, 8'h77);
    chk("rel_out1", 8'h77, pin_out[39:32]);
    xfer(1'b0, dio_pkg::MODE_REL_BYTE, 7'h0a, 8'h00);
    chk("rel_none", 8'h01, {7'h00, er});
    xfer(1'b1, dio_pkg::MODE_REL_BIT, 7'h02, 8'h01);
    chk("rel_bit_out", 8'h04, pin_out[15:8]);
    xfer(1'b0, dio_pkg::MODE_REL_BIT, 7'h0c, 8'h00);
    chk("rel_bit_in", 8'h01, rd);
  endtask : t_relative

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence after a 20-cycle reset.
  initial begin
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
    t_start();
    t_inputs();
    t_preset();
    t_bits();
    t_relative();
    report_and_stop();
  end

  // Cuts a hang short well beyond the expected run of under a hundred cycles.
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule : ninety_six_line_digital_io_tb_top

`default_nettype wire
